//--- dv/dcb_host.sv
// host model issuing single word register accesses
`timescale 1ns/10ps
module dcb_host
  import dcb_pkg::*;
(
  input wire logic clk_sys,
  output host_req_t req,
  input wire logic [31:0] rdata_ff
);
  initial req = '{1'b0, 1'b0, 16'h0, 32'h0};
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(negedge clk_sys);
    req = '{w, !w, a, d};
    @(negedge clk_sys);
    q = rdata_ff;
    // idle bus shows inverted values, never the last request
    req = '{1'b0, 1'b0, ~a, ~d};
  endtask : acc
endmodule : dcb_host

//--- dv/dcb_monitor.sv
// concurrent checks on the channel buffer register bank ports
`timescale 1ns/10ps
module dcb_monitor
  import dcb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input host_req_t req,
  input wire logic acq_run,
  input wire logic [NCH-1:0] dac_busy,
  input chan_cfg_t cfg_ff,
  input logic [10:0] num_blocks_ff,
  input logic sw_clear_ff,
  input logic [NCH-1:0] dac_load_ff,
  input logic [NCH-1:0] adc_calib_ff,
  input logic [NCH-1:0] adc_pdn_ff,
  input logic write_while_run_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire div_wr = req.wr && req.addr == 16'h800c;
  property p_clear; div_wr |=> sw_clear_ff; endproperty
  a_clear: assert property (p_clear) else $error("no clear after division write");
  property p_blocks;
    div_wr && req.wdata[3:0] <= 4'ha |=> num_blocks_ff == (11'h1 << $past(req.wdata[3:0]));
  endproperty
  a_blocks: assert property (p_blocks) else $error("block count wrong");
  property p_dac; dac_load_ff[0] |-> !$past(dac_busy[0]); endproperty
  a_dac: assert property (p_dac) else $error("offset loaded while busy");
  property p_adc;
    req.wr && req.addr == 16'h109c |=> adc_calib_ff[0] == $past(req.wdata[1])
      && adc_pdn_ff[0] == $past(req.wdata[0]);
  endproperty
  a_adc: assert property (p_adc) else $error("converter control wrong");
  property p_set; req.wr && req.addr == 16'h8004 && req.wdata[3] |=> cfg_ff.test_pattern; endproperty
  a_set: assert property (p_set) else $error("set alias failed");
  property p_clr; req.wr && req.addr == 16'h8008 && req.wdata[4] |=> !cfg_ff.seq_access; endproperty
  a_clr: assert property (p_clr) else $error("clear alias failed");
  property p_cfg;
    req.wr && req.addr == 16'h8000 |=> cfg_ff.dual_rate == $past(req.wdata[12])
      ##0 cfg_ff.trig_overlap == $past(req.wdata[1]);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config write wrong");
  property p_run; div_wr && acq_run |=> write_while_run_ff; endproperty
  a_run: assert property (p_run) else $error("write in run not flagged");
endmodule : dcb_monitor

//--- dv/tb_digitizer_channel_buffer_regs.sv
// testbench for the channel buffer register bank
`timescale 1ns/10ps
module tb_digitizer_channel_buffer_regs;
  import dcb_pkg::*;
  logic clk_sys = 0;
  logic srst = 1;
  logic acq_run = 0;
  logic [7:0] ovt = 0, cal_b = 0, dbusy = 0, filled = 0;
  logic [3:0][7:0] ctemp = '0;
  host_req_t req;
  logic [31:0] rdata, lpe, q;
  logic ack, swc, cen, wwr;
  chan_cfg_t cfg;
  logic [3:0] div, spl;
  logic [10:0] nb;
  logic [7:0] dl, acal, apdn;
  logic [15:0] dc [NCH];
  int error_cnt = 0;
  int total_checks = 0;
  always #10 clk_sys = ~clk_sys;
  dcb_host h (.clk_sys(clk_sys), .req(req), .rdata_ff(rdata));
  digitizer_channel_buffer_regs dut (.clk_sys(clk_sys), .srst(srst), .req(req),
    .rdata_ff(rdata), .ack_ff(ack), .acq_run(acq_run), .over_temp(ovt),
    .calib_busy(cal_b), .dac_busy(dbusy), .blk_filled(filled), .conv_temp(ctemp),
    .cfg_ff(cfg), .div_code_ff(div), .num_blocks_ff(nb), .sw_clear_ff(swc),
    .custom_en_ff(cen), .locations_per_event_ff(lpe), .samples_per_location_ff(spl),
    .dac_load_ff(dl), .dac_code_ff(dc), .adc_calib_ff(acal), .adc_pdn_ff(apdn),
    .write_while_run_ff(wwr));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    h.acc(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [15:0] a, input logic [31:0] e);
    h.acc(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), e, q);
  endtask : rc
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    #100us;
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    srst = 0;
    rc(16'h8000, 32'h10);
    rc(16'h1088, 32'h42);
    rc(16'h108c, 32'h100);
    rc(16'h1094, 32'h0);
    rc(16'h8030, 32'h0);
    $display("reset test done");
    wr(16'h8000, 32'hffffffff);
    rc(16'h8000, 32'h105a);
    wr(16'h8008, 32'h1010);
    rc(16'h8000, 32'h004a);
    wr(16'h8004, 32'h1018);
    rc(16'h8000, 32'h105a);
    wr(16'h8008, 32'hffff);
    rc(16'h8000, 32'h0);
    $display("config test done");
    dbusy = 8'h01;
    wr(16'h1098, 32'h1234);
    repeat (4) @(negedge clk_sys);
    chk("dac load", 32'h0, dl);
    rc(16'h1098, 32'h1234);
    ovt = 8'h01;
    cal_b = 8'h01;
    ctemp[1] = 8'h2a;
    rc(16'h1088, 32'h106);
    wr(16'h109c, 32'h3);
    chk("calib", 32'h1, acal);
    rc(16'h109c, 32'h0);
    rc(16'h1088, 32'h186);
    rc(16'h12a8, 32'h2a);
    rc(16'h13a8, 32'h2a);
    ovt = 0;
    cal_b = 0;
    dbusy = 0;
    repeat (3) @(negedge clk_sys);
    chk("dac code", 32'h1234, dc[0]);
    $display("channel test done");
    wr(16'h800c, 32'h1);
    chk("clear", 32'h1, swc);
    chk("blocks", 32'h2, nb);
    repeat (3) begin
      filled = 8'h01;
      @(negedge clk_sys);
      filled = 0;
      @(negedge clk_sys);
    end
    rc(16'h1094, 32'h2);
    rc(16'h1088, 32'hc1);
    wr(16'h8010, 32'h3);
    rc(16'h1088, 32'he1);
    wr(16'h8010, 32'h1);
    rc(16'h1094, 32'h1);
    rc(16'h1088, 32'hc0);
    wr(16'h800c, 32'ha);
    chk("max blocks", 32'h400, nb);
    chk("div code", 32'ha, div);
    @(negedge clk_sys);
    rc(16'h1088, 32'hc2);
    $display("buffer test done");
    wr(16'h8020, 32'h5);
    chk("custom", 32'h1, cen);
    chk("locations", 32'h5, lpe);
    wr(16'h8004, 32'h1000);
    chk("samples", 32'he, spl);
    acq_run = 1;
    wr(16'h8020, 32'h0);
    chk("run flag", 32'h1, wwr);
    chk("custom off", 32'h0, cen);
    wr(16'h800c, 32'h0);
    acq_run = 0;
    $display("custom test done");
    give_verdict;
  end
endmodule : tb_digitizer_channel_buffer_regs
bind digitizer_channel_buffer_regs dcb_monitor mon (.clk_sys(clk_sys), .srst(srst),
  .req(req), .acq_run(acq_run), .dac_busy(dac_busy), .cfg_ff(cfg_ff),
  .num_blocks_ff(num_blocks_ff), .sw_clear_ff(sw_clear_ff), .dac_load_ff(dac_load_ff),
  .adc_calib_ff(adc_calib_ff), .adc_pdn_ff(adc_pdn_ff),
  .write_while_run_ff(write_while_run_ff));

//--- logic/dcb_map.svh
// register offsets, field positions and reset values of the channel buffer register bank
`ifndef DCB_MAP_SVH
`define DCB_MAP_SVH
`define CH_PAGE 4'h1
`define CH_STATUS 8'h88
`define CH_FW 8'h8c
`define CH_OCC 8'h94
`define CH_DAC 8'h98
`define CH_ADC 8'h9c
`define CH_TEMP 8'ha8
`define CFG_ADDR 16'h8000
`define CFG_SET_ADDR 16'h8004
`define CFG_CLR_ADDR 16'h8008
`define BUF_DIV_ADDR 16'h800c
`define BUF_FREE_ADDR 16'h8010
`define CUSTOM_ADDR 16'h8020
`define CFG_RESET 13'h0010
`define CFG_MASK 13'h105a
`define CFG_DUAL 12
`define CFG_UNDER 6
`define CFG_SEQ 4
`define CFG_TEST 3
`define CFG_OVL 1
`define ST_OVT 8
`define ST_PDN 7
`define ST_CAL 6
`define ST_BFERR 5
`define ST_BUSY 2
`define ST_EMPTY 1
`define ST_FULL 0
`define ADC_CAL 1
`define ADC_PDN 0
`define DIV_MAX 4'ha
`define SPL_BASE 4'h7
`define SPL_DUAL 4'he
`endif

//--- logic/dcb_pkg.sv
// types shared by the channel buffer register bank
package dcb_pkg;
  localparam int NCH = 8;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } host_req_t;
  typedef struct packed {
    logic dual_rate;
    logic trig_under;
    logic seq_access;
    logic test_pattern;
    logic trig_overlap;
  } chan_cfg_t;
endpackage : dcb_pkg

//--- logic/digitizer_channel_buffer_regs.sv
// register bank for channel status, offsets, converter control and output buffer setup
//
// How it works
// - status bit 8 shows converter over temperature.
// - status bit 6 is 0 during calibration, 1 when done.
// - status bit 5 sets when freeing more blocks than are occupied.
// - status bit 2 dac busy, bit 1 memory empty, bit 0 memory full.
// - firmware word holds date, major and minor revision.
// - occupancy word counts filled output blocks, 0 to 1024.
// - offset register holds a 16-bit dc offset code.
// - new offset code goes to the dac only while it is not busy.
// - converter control drives calibration from bit 1, power down from bit 0.
// - temperature word returns the shared converter temperature per channel pair.
// - config bit 12 picks base rate or dual edge sampling.
// - config bit 6 picks trigger above or below threshold.
// - config bit 4 picks random or sequential memory access.
// - config bit 3 enables test pattern.
// - config bit 1 enables overlapping trigger handling.
// - set and clear aliases change only the config bits written as 1.
// - division code splits buffer into 2 to the code blocks, up to 1024.
// - any division write also issues a software clear.
// - writing N to buffer free releases the oldest N blocks.
// - custom size 0 disables it, else gives locations per event.
// - acquisition running follows the run bit of acquisition control.
`timescale 1ns/10ps
`include "dcb_map.svh"

module digitizer_channel_buffer_regs
  import dcb_pkg::*;
#(
  parameter logic [15:0] FW_DATE = 16'h0000, // arbitrary value
  parameter logic [7:0] FW_MAJOR = 8'h01, // arbitrary value
  parameter logic [7:0] FW_MINOR = 8'h00 // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic srst,
  input host_req_t req,
  output logic [31:0] rdata_ff,
  output logic ack_ff,
  input wire logic acq_run,
  input wire logic [NCH-1:0] over_temp,
  input wire logic [NCH-1:0] calib_busy,
  input wire logic [NCH-1:0] dac_busy,
  input wire logic [NCH-1:0] blk_filled,
  input wire logic [NCH/2-1:0][7:0] conv_temp,
  output chan_cfg_t cfg_ff,
  output logic [3:0] div_code_ff,
  output logic [10:0] num_blocks_ff,
  output logic sw_clear_ff,
  output logic custom_en_ff,
  output logic [31:0] locations_per_event_ff,
  output logic [3:0] samples_per_location_ff,
  output logic [NCH-1:0] dac_load_ff,
  output logic [15:0] dac_code_ff [NCH],
  output logic [NCH-1:0] adc_calib_ff,
  output logic [NCH-1:0] adc_pdn_ff,
  output logic write_while_run_ff
);

  // address decode
  wire ch_page = (req.addr[15:12] == `CH_PAGE) && !req.addr[11];
  wire [2:0] ch_idx = req.addr[10:8];
  wire [7:0] ch_reg = req.addr[7:0];
  wire cfg_wr = req.wr && (req.addr == `CFG_ADDR);
  wire set_wr = req.wr && (req.addr == `CFG_SET_ADDR);
  wire clr_wr = req.wr && (req.addr == `CFG_CLR_ADDR);
  wire div_wr = req.wr && (req.addr == `BUF_DIV_ADDR);
  wire free_wr = req.wr && (req.addr == `BUF_FREE_ADDR);
  wire custom_wr = req.wr && (req.addr == `CUSTOM_ADDR);

  // configuration register with set and clear aliases
  logic [12:0] cfg_raw_ff;
  logic [12:0] nxt_cfg_raw;
  wire [12:0] cfg_rst = `CFG_RESET;
  wire [12:0] wbits = req.wdata[12:0] & `CFG_MASK;
  assign nxt_cfg_raw = cfg_wr ? wbits :
                       set_wr ? (cfg_raw_ff | wbits) :
                       clr_wr ? (cfg_raw_ff & ~wbits) :
                       cfg_raw_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_raw_ff <= `CFG_RESET;
    end else begin
      cfg_raw_ff <= nxt_cfg_raw;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_ff <= '0;
      cfg_ff.seq_access <= cfg_rst[`CFG_SEQ];
    end else begin
      cfg_ff.dual_rate <= nxt_cfg_raw[`CFG_DUAL];
      cfg_ff.trig_under <= nxt_cfg_raw[`CFG_UNDER];
      cfg_ff.seq_access <= nxt_cfg_raw[`CFG_SEQ];
      cfg_ff.test_pattern <= nxt_cfg_raw[`CFG_TEST];
      cfg_ff.trig_overlap <= nxt_cfg_raw[`CFG_OVL];
    end
  end

  // samples held by one memory location follow the sampling rate
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      samples_per_location_ff <= `SPL_BASE;
    end else begin
      samples_per_location_ff <= nxt_cfg_raw[`CFG_DUAL] ? `SPL_DUAL : `SPL_BASE;
    end
  end

  // buffer division, software clear and block count
  wire [3:0] div_clamped = (req.wdata[3:0] > `DIV_MAX) ? `DIV_MAX : req.wdata[3:0];
  wire [10:0] div_blocks = 11'h001 << div_clamped;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_code_ff <= 4'h0;
      num_blocks_ff <= 11'h001;
      sw_clear_ff <= 1'b0;
    end else begin
      sw_clear_ff <= div_wr;
      if (div_wr) begin
        div_code_ff <= req.wdata[3:0];
        num_blocks_ff <= div_blocks;
      end
    end
  end

  // last value written to buffer free
  logic [11:0] free_n_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      free_n_ff <= 12'h000;
    end else if (free_wr) begin
      free_n_ff <= req.wdata[11:0];
    end
  end

  // custom event size
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      locations_per_event_ff <= 32'h0000_0000;
      custom_en_ff <= 1'b0;
    end else if (custom_wr) begin
      locations_per_event_ff <= req.wdata;
      custom_en_ff <= (req.wdata != 32'h0000_0000);
    end
  end

  // flags a forbidden buffer setup write during a run
  wire bad_wr = (div_wr || custom_wr) && acq_run;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      write_while_run_ff <= 1'b0;
    end else begin
      write_while_run_ff <= bad_wr;
    end
  end

  // per channel state
  logic [10:0] occ_ff [NCH];
  logic bferr_ff [NCH];
  logic [15:0] dac_ff [NCH];
  logic dac_pend_ff [NCH];
  logic [31:0] st_word [NCH];
  logic [31:0] ch_word [NCH];

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire sel = ch_page && (ch_idx == 3'(c));
    wire dac_wr = req.wr && sel && (ch_reg == `CH_DAC);
    wire adc_wr = req.wr && sel && (ch_reg == `CH_ADC);
    wire full = (occ_ff[c] >= num_blocks_ff);
    wire [10:0] inc = (blk_filled[c] && !full) ? 11'h001 : 11'h000;
    wire free_ok = free_wr && (req.wdata[11:0] <= {1'b0, occ_ff[c]});
    wire free_err = free_wr && !free_ok;
    wire [10:0] dec = free_ok ? req.wdata[10:0] : 11'h000;
    wire [10:0] nxt_occ = sw_clear_ff ? 11'h000 : (occ_ff[c] + inc - dec);
    wire dac_go = dac_pend_ff[c] && !dac_busy[c];

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        occ_ff[c] <= 11'h000;
      end else begin
        occ_ff[c] <= nxt_occ;
      end
    end

    // set wins over clear
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        bferr_ff[c] <= 1'b0;
      end else if (free_err) begin
        bferr_ff[c] <= 1'b1;
      end else if (free_ok || sw_clear_ff) begin
        bferr_ff[c] <= 1'b0;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        dac_ff[c] <= 16'h0000;
        dac_pend_ff[c] <= 1'b0;
      end else if (dac_wr) begin
        dac_ff[c] <= req.wdata[15:0];
        dac_pend_ff[c] <= 1'b1;
      end else if (dac_go) begin
        dac_pend_ff[c] <= 1'b0;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        dac_load_ff[c] <= 1'b0;
        dac_code_ff[c] <= 16'h0000;
      end else begin
        dac_load_ff[c] <= dac_go;
        if (dac_go) begin
          dac_code_ff[c] <= dac_ff[c];
        end
      end
    end

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        adc_calib_ff[c] <= 1'b0;
        adc_pdn_ff[c] <= 1'b0;
      end else if (adc_wr) begin
        adc_calib_ff[c] <= req.wdata[`ADC_CAL];
        adc_pdn_ff[c] <= req.wdata[`ADC_PDN];
      end
    end

    always_comb begin
      st_word[c] = 32'h0000_0000;
      st_word[c][`ST_OVT] = over_temp[c];
      st_word[c][`ST_PDN] = adc_pdn_ff[c];
      st_word[c][`ST_CAL] = !calib_busy[c];
      st_word[c][`ST_BFERR] = bferr_ff[c];
      st_word[c][`ST_BUSY] = dac_busy[c];
      st_word[c][`ST_EMPTY] = (occ_ff[c] == 11'h000);
      st_word[c][`ST_FULL] = full;
    end

    always_comb begin
      unique case (ch_reg)
        `CH_STATUS: ch_word[c] = st_word[c];
        `CH_FW: ch_word[c] = {FW_DATE, FW_MAJOR, FW_MINOR};
        `CH_OCC: ch_word[c] = {21'h000000, occ_ff[c]};
        `CH_DAC: ch_word[c] = {16'h0000, dac_ff[c]};
        `CH_TEMP: ch_word[c] = {24'h000000, conv_temp[c/2]};
        default: ch_word[c] = 32'h0000_0000;
      endcase
    end
  end

  // read selection
  wire [31:0] glb_word =
    (req.addr == `CFG_ADDR) ? {19'h00000, cfg_raw_ff} :
    (req.addr == `BUF_DIV_ADDR) ? {28'h0000000, div_code_ff} :
    (req.addr == `BUF_FREE_ADDR) ? {20'h00000, free_n_ff} :
    (req.addr == `CUSTOM_ADDR) ? locations_per_event_ff :
    32'h0000_0000;
  wire [31:0] rd_mux = ch_page ? ch_word[ch_idx] : glb_word;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_ff <= 32'h0000_0000;
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req.wr || req.rd;
      if (req.rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

endmodule : digitizer_channel_buffer_regs
